/* File: shared/ppcor_pkg.sv */
/*
  Shared constants for the port register and pin-change override block.
  Assumes a 6-bit register address and 8-bit register data.
*/
package ppcor_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int J_W = 7;

  // Register offsets
  localparam logic [5:0] A_PIN_OFS = 6'h00;
  localparam logic [5:0] A_DIR_OFS = 6'h01;
  localparam logic [5:0] A_DATA_OFS = 6'h02;
  localparam logic [5:0] B_PIN_OFS = 6'h03;
  localparam logic [5:0] B_DIR_OFS = 6'h04;
  localparam logic [5:0] B_DATA_OFS = 6'h05;
  localparam logic [5:0] J_PIN_OFS = 6'h10;
  localparam logic [5:0] J_DIR_OFS = 6'h11;
  localparam logic [5:0] J_DATA_OFS = 6'h12;
  localparam logic [5:0] PC_MASK_OFS = 6'h13;
  localparam logic [5:0] PC_CTRL_OFS = 6'h14;
  localparam logic [5:0] INT_STAT_OFS = 6'h15;
  localparam logic [5:0] INT_MASK_OFS = 6'h16;

  // Field positions and values
  localparam int PC_GRP_EN_BIT = 0;
  localparam logic [7:0] RD_ZERO = 8'h00;
  localparam logic [2:0] J_UPPER_OVR = 3'h0;
  localparam logic [3:0] J_LOWER_OVR = 4'h0;
  localparam logic J_DIE_OVR_VAL = 1'h0;
  localparam logic IE_NORMAL = 1'h1;

  function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit
endpackage : ppcor_pkg

/* File: logic/ppcor_port.sv */
/*
  One port: output data, direction and sampled input pins.
  Assumes pins are synchronous to mclk and the bus strobes are one cycle.
*/
module ppcor_port #(
  parameter int W = 8,
  parameter logic [5:0] PIN_OFS = 6'h00,
  parameter logic [5:0] DIR_OFS = 6'h01,
  parameter logic [5:0] DATA_OFS = 6'h02
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] data_q,
  output logic [W-1:0] dir_q,
  output logic [W-1:0] pins_q,
  output logic [7:0] rd_val,
  output logic hit
);
  typedef struct packed {
    logic [W-1:0] data;
    logic [W-1:0] dir;
    logic [W-1:0] pins;
  } ppcor_port_state_t;

  localparam ppcor_port_state_t PORT_RESET = '0;

  ppcor_port_state_t s_reg;
  ppcor_port_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.pins = pins_in;
    if (wr && ppcor_pkg::reg_hit(addr, DATA_OFS)) begin
      s_next.data = wdata[W-1:0];
    end
    if (wr && ppcor_pkg::reg_hit(addr, DIR_OFS)) begin
      s_next.dir = wdata[W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= PORT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    rd_val = ppcor_pkg::RD_ZERO;
    hit = 1'b1;
    if (ppcor_pkg::reg_hit(addr, PIN_OFS)) begin
      rd_val[W-1:0] = s_reg.pins;
    end else if (ppcor_pkg::reg_hit(addr, DIR_OFS)) begin
      rd_val[W-1:0] = s_reg.dir;
    end else if (ppcor_pkg::reg_hit(addr, DATA_OFS)) begin
      rd_val[W-1:0] = s_reg.data;
    end else begin
      hit = 1'b0;
    end
  end

  assign data_q = s_reg.data;
  assign dir_q = s_reg.dir;
  assign pins_q = s_reg.pins;
endmodule : ppcor_port

/* File: logic/ppcor_override.sv */
/*
  Override signals of the seven-pin port and the generic resolution of
  pull-up, direction, output value and input enable. Purely combinational.
*/
module ppcor_override (
  input wire logic [6:0] data,
  input wire logic [6:0] dir,
  input wire logic [6:0] pc_mask,
  input wire logic grp_en,
  output logic [6:0] pu_oe,
  output logic [6:0] dd_oe,
  output logic [6:0] pv_oe,
  output logic [6:0] die_oe,
  output logic [6:0] pu_level,
  output logic [6:0] drive_en,
  output logic [6:0] out_val,
  output logic [6:0] in_en
);
  logic [6:0] ovr_zero;

  assign ovr_zero = {ppcor_pkg::J_UPPER_OVR, ppcor_pkg::J_LOWER_OVR};

  always_comb begin
    pu_oe = ovr_zero;
    dd_oe = ovr_zero;
    pv_oe = ovr_zero;
    die_oe = pc_mask & {7{grp_en}};
    for (int i = 0; i < 7; i++) begin
      pu_level[i] = pu_oe[i] ? ovr_zero[i] : (data[i] & ~dir[i]);
      drive_en[i] = dd_oe[i] ? ovr_zero[i] : dir[i];
      out_val[i] = pv_oe[i] ? ovr_zero[i] : data[i];
      in_en[i] = die_oe[i] ? ppcor_pkg::J_DIE_OVR_VAL : ppcor_pkg::IE_NORMAL;
    end
  end
endmodule : ppcor_override

/* File: logic/ppcor_top.sv */
/*
  Ports A and B registers, the seven-pin port with its pin-change override
  wiring, pin-change interrupt status and mask, and a simple register port.
  Assumes pins synchronous to mclk and a master that never overlaps strobes.
*/
// What this block does
// - Seventh-port bits 6..0 drive pin-change sources 30..24.
// - Upper three seventh-port pins: pull-up, direction, value overrides held zero.
// - Lower four seventh-port pins: pull-up, direction, value overrides held zero.
// - Input-enable override enable is mask bit AND group enable; value zero.
// - Port A output data at 0x02, read/write, resets to zero.
// - Port A direction at 0x01, read/write, resets to zero.
// - Port A input pins at 0x00 return sampled pin levels.
// - Port B output data at 0x05, read/write, resets to zero.
// - Port B direction at 0x04, read/write.
module ppcor_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_a_pullup,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_b_pullup,
  input wire logic [6:0] port_j_in,
  output logic [6:0] port_j_out,
  output logic [6:0] port_j_oe,
  output logic [6:0] port_j_pullup,
  output logic [6:0] port_j_in_en,
  output logic [6:0] pin_change_source,
  output logic irq
);
  typedef struct packed {
    logic [6:0] pc_mask;
    logic grp_en;
    logic [6:0] int_stat;
    logic [6:0] int_mask;
    logic [6:0] prev_src;
    logic [7:0] rdata;
    logic irq;
    logic [7:0] a_out;
    logic [7:0] a_oe;
    logic [7:0] a_pu;
    logic [7:0] b_out;
    logic [7:0] b_oe;
    logic [7:0] b_pu;
    logic [6:0] j_out;
    logic [6:0] j_oe;
    logic [6:0] j_pu;
    logic [6:0] j_ie;
    logic [6:0] pc_src;
  } ppcor_top_state_t;

  localparam ppcor_top_state_t TOP_RESET = '0;

  ppcor_top_state_t s_reg;
  ppcor_top_state_t s_next;

  logic [7:0] a_data, a_dir, a_pins, a_rd;
  logic [7:0] b_data, b_dir, b_rd;
  logic [6:0] j_data, j_dir, j_pins;
  logic [7:0] j_rd;
  logic a_hit, b_hit, j_hit;
  logic [6:0] pu_oe, dd_oe, pv_oe, die_oe;
  logic [6:0] j_pu, j_oe, j_out, j_ie;
  logic [6:0] pc_event;
  logic [7:0] own_rd;

  ppcor_port #(
    .W(8),
    .PIN_OFS(ppcor_pkg::A_PIN_OFS),
    .DIR_OFS(ppcor_pkg::A_DIR_OFS),
    .DATA_OFS(ppcor_pkg::A_DATA_OFS)
  ) u_port_a (
    .mclk(mclk),
    .arst_n(arst_n),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .pins_in(port_a_in),
    .data_q(a_data),
    .dir_q(a_dir),
    .pins_q(a_pins),
    .rd_val(a_rd),
    .hit(a_hit)
  );

  ppcor_port #(
    .W(8),
    .PIN_OFS(ppcor_pkg::B_PIN_OFS),
    .DIR_OFS(ppcor_pkg::B_DIR_OFS),
    .DATA_OFS(ppcor_pkg::B_DATA_OFS)
  ) u_port_b (
    .mclk(mclk),
    .arst_n(arst_n),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .pins_in(port_b_in),
    .data_q(b_data),
    .dir_q(b_dir),
    .pins_q(),
    .rd_val(b_rd),
    .hit(b_hit)
  );

  ppcor_port #(
    .W(ppcor_pkg::J_W),
    .PIN_OFS(ppcor_pkg::J_PIN_OFS),
    .DIR_OFS(ppcor_pkg::J_DIR_OFS),
    .DATA_OFS(ppcor_pkg::J_DATA_OFS)
  ) u_port_j (
    .mclk(mclk),
    .arst_n(arst_n),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .pins_in(port_j_in),
    .data_q(j_data),
    .dir_q(j_dir),
    .pins_q(j_pins),
    .rd_val(j_rd),
    .hit(j_hit)
  );

  ppcor_override u_override (
    .data(j_data),
    .dir(j_dir),
    .pc_mask(s_reg.pc_mask),
    .grp_en(s_reg.grp_en),
    .pu_oe(pu_oe),
    .dd_oe(dd_oe),
    .pv_oe(pv_oe),
    .die_oe(die_oe),
    .pu_level(j_pu),
    .drive_en(j_oe),
    .out_val(j_out),
    .in_en(j_ie)
  );

  // Pin-change events on enabled, unmasked sources
  assign pc_event = (j_pins ^ s_reg.prev_src) & s_reg.pc_mask & {7{s_reg.grp_en}};

  always_comb begin
    own_rd = ppcor_pkg::RD_ZERO;
    case (1'b1)
      ppcor_pkg::reg_hit(addr, ppcor_pkg::PC_MASK_OFS): own_rd[6:0] = s_reg.pc_mask;
      ppcor_pkg::reg_hit(addr, ppcor_pkg::PC_CTRL_OFS):
        own_rd[ppcor_pkg::PC_GRP_EN_BIT] = s_reg.grp_en;
      ppcor_pkg::reg_hit(addr, ppcor_pkg::INT_STAT_OFS): own_rd[6:0] = s_reg.int_stat;
      ppcor_pkg::reg_hit(addr, ppcor_pkg::INT_MASK_OFS): own_rd[6:0] = s_reg.int_mask;
      default: own_rd = ppcor_pkg::RD_ZERO;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.prev_src = j_pins;
    s_next.pc_src = j_pins;
    // Read data stand for the one cycle after the strobe
    s_next.rdata = ppcor_pkg::RD_ZERO;
    if (rd) begin
      if (a_hit) begin
        s_next.rdata = a_rd;
      end else if (b_hit) begin
        s_next.rdata = b_rd;
      end else if (j_hit) begin
        s_next.rdata = j_rd;
      end else begin
        s_next.rdata = own_rd;
      end
    end
    if (wr && ppcor_pkg::reg_hit(addr, ppcor_pkg::PC_MASK_OFS)) begin
      s_next.pc_mask = wdata[6:0];
    end
    if (wr && ppcor_pkg::reg_hit(addr, ppcor_pkg::PC_CTRL_OFS)) begin
      s_next.grp_en = wdata[ppcor_pkg::PC_GRP_EN_BIT];
    end
    if (wr && ppcor_pkg::reg_hit(addr, ppcor_pkg::INT_MASK_OFS)) begin
      s_next.int_mask = wdata[6:0];
    end
    // Write one clears; a new event in the same cycle wins
    if (wr && ppcor_pkg::reg_hit(addr, ppcor_pkg::INT_STAT_OFS)) begin
      s_next.int_stat = s_reg.int_stat & ~wdata[6:0];
    end
    s_next.int_stat = s_next.int_stat | pc_event;
    s_next.irq = |(s_next.int_stat & s_next.int_mask);
    // Pin controls follow the registers
    s_next.a_out = a_data;
    s_next.a_oe = a_dir;
    s_next.a_pu = a_data & ~a_dir;
    s_next.b_out = b_data;
    s_next.b_oe = b_dir;
    s_next.b_pu = b_data & ~b_dir;
    s_next.j_out = j_out;
    s_next.j_oe = j_oe;
    s_next.j_pu = j_pu;
    s_next.j_ie = j_ie;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= TOP_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign irq = s_reg.irq;
  assign port_a_out = s_reg.a_out;
  assign port_a_oe = s_reg.a_oe;
  assign port_a_pullup = s_reg.a_pu;
  assign port_b_out = s_reg.b_out;
  assign port_b_oe = s_reg.b_oe;
  assign port_b_pullup = s_reg.b_pu;
  assign port_j_out = s_reg.j_out;
  assign port_j_oe = s_reg.j_oe;
  assign port_j_pullup = s_reg.j_pu;
  assign port_j_in_en = s_reg.j_ie;
  assign pin_change_source = s_reg.pc_src;

  // Checks
  property p_src_map;
    @(posedge mclk) disable iff (!arst_n)
    ##2 pin_change_source == $past(port_j_in, 2);
  endproperty
  a_src_map: assert property (p_src_map) else $error("pin-change source mismatch");

  property p_upper_ovr;
    @(posedge mclk) disable iff (!arst_n)
    (pu_oe[6:4] | dd_oe[6:4] | pv_oe[6:4]) == ppcor_pkg::J_UPPER_OVR;
  endproperty
  a_upper_ovr: assert property (p_upper_ovr) else $error("upper override not zero");

  property p_lower_ovr;
    @(posedge mclk) disable iff (!arst_n)
    ##1 (port_j_oe[3:0] == $past(j_dir[3:0]))
      && (port_j_out[3:0] == $past(j_data[3:0]));
  endproperty
  a_lower_ovr: assert property (p_lower_ovr) else $error("lower pins overridden");

  property p_die_ovr;
    @(posedge mclk) disable iff (!arst_n)
    // First edge after reset still shows the reset value
    arst_n |=> port_j_in_en == ~$past(s_reg.pc_mask & {7{s_reg.grp_en}});
  endproperty
  a_die_ovr: assert property (p_die_ovr) else $error("input enable override wrong");

  property p_a_data;
    @(posedge mclk) disable iff (!arst_n)
    (wr && addr == ppcor_pkg::A_DATA_OFS) |-> ##2 port_a_out == $past(wdata, 2);
  endproperty
  a_a_data: assert property (p_a_data) else $error("port A data not written");

  property p_a_dir_rd;
    @(posedge mclk) disable iff (!arst_n)
    (rd && addr == ppcor_pkg::A_DIR_OFS) |=> rdata == $past(a_dir);
  endproperty
  a_a_dir_rd: assert property (p_a_dir_rd) else $error("port A direction readback");

  property p_a_pin_rd;
    @(posedge mclk) disable iff (!arst_n)
    (rd && addr == ppcor_pkg::A_PIN_OFS) ##1 1'b1 |-> rdata == $past(port_a_in, 2);
  endproperty
  a_a_pin_rd: assert property (p_a_pin_rd) else $error("port A pin readback");

  property p_b_data;
    @(posedge mclk) disable iff (!arst_n)
    (wr && addr == ppcor_pkg::B_DATA_OFS) |-> ##2 port_b_out == $past(wdata, 2);
  endproperty
  a_b_data: assert property (p_b_data) else $error("port B data not written");

  property p_b_dir;
    @(posedge mclk) disable iff (!arst_n)
    (wr && addr == ppcor_pkg::B_DIR_OFS) |-> ##2 port_b_oe == $past(wdata, 2);
  endproperty
  a_b_dir: assert property (p_b_dir) else $error("port B direction not written");

  property p_follow;
    @(posedge mclk) disable iff (!arst_n)
    ##1 port_a_pullup == $past(a_data & ~a_dir);
  endproperty
  a_follow: assert property (p_follow) else $error("port A pull-up wrong");

  property p_irq;
    @(posedge mclk) disable iff (!arst_n)
    irq == |(s_reg.int_stat & s_reg.int_mask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_rd_idle;
    @(posedge mclk) disable iff (!arst_n)
    !rd |=> rdata == ppcor_pkg::RD_ZERO;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

  property p_die_oe;
    @(posedge mclk) disable iff (!arst_n)
    die_oe == (s_reg.pc_mask & {7{s_reg.grp_en}});
  endproperty
  a_die_oe: assert property (p_die_oe) else $error("input enable override enable wrong");

  property p_a_dir;
    @(posedge mclk) disable iff (!arst_n)
    (wr && addr == ppcor_pkg::A_DIR_OFS) |-> ##2 port_a_oe == $past(wdata, 2);
  endproperty
  a_a_dir: assert property (p_a_dir) else $error("port A direction not written");

  property p_a_data_rd;
    @(posedge mclk) disable iff (!arst_n)
    (rd && addr == ppcor_pkg::A_DATA_OFS) |=> rdata == $past(a_data);
  endproperty
  a_a_data_rd: assert property (p_a_data_rd) else $error("port A data readback");

  property p_a_pins;
    @(posedge mclk) disable iff (!arst_n)
    ##1 a_pins == $past(port_a_in);
  endproperty
  a_a_pins: assert property (p_a_pins) else $error("port A pins not sampled");

  property p_b_dir_rd;
    @(posedge mclk) disable iff (!arst_n)
    (rd && addr == ppcor_pkg::B_DIR_OFS) |=> rdata == $past(b_dir);
  endproperty
  a_b_dir_rd: assert property (p_b_dir_rd) else $error("port B direction readback");

  property p_b_follow;
    @(posedge mclk) disable iff (!arst_n)
    ##1 port_b_pullup == $past(b_data & ~b_dir);
  endproperty
  a_b_follow: assert property (p_b_follow) else $error("port B pull-up wrong");

  property p_upper_follow;
    @(posedge mclk) disable iff (!arst_n)
    ##1 port_j_pullup[6:4] == $past(j_data[6:4] & ~j_dir[6:4]);
  endproperty
  a_upper_follow: assert property (p_upper_follow) else $error("upper pull-up overridden");
endmodule : ppcor_top

/* File: tb/ppcor_board.sv */
/*
  Board model of the pins attached to one port.
  Assumes the port drives a pin only where its output enable is high;
  elsewhere the board's own level reaches the pin.
*/
module ppcor_board #(
  parameter int W = 8
) (
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven bits show the port value, the others the board level
  assign pin = (oe & out) | (~oe & ext);
endmodule : ppcor_board

/* File: tb/ppcor_bench.sv */
/*
  Self-checking bench for the port register and pin-change block.
  Assumes the register port of the top module and board models on all pins.
*/
module ppcor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, a_in, a_out, a_oe, a_pu, b_in, b_out, b_oe, b_pu;
  logic [6:0] j_in, j_out, j_oe, j_pu, j_ie, pcs;
  logic irq;
  logic [7:0] ext_a = 8'h00;
  logic [7:0] ext_b = 8'h00;
  logic [6:0] ext_j = 7'h00;
  logic [7:0] d0, d1, d2, d3;
  int failures = 0;
  int n_tests = 0;
  int seed = 11;
  int cyc = 0;

  always #4 mclk = ~mclk;

  ppcor_top i_dut (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .port_a_in(a_in), .port_a_out(a_out), .port_a_oe(a_oe),
    .port_a_pullup(a_pu), .port_b_in(b_in), .port_b_out(b_out), .port_b_oe(b_oe),
    .port_b_pullup(b_pu), .port_j_in(j_in), .port_j_out(j_out), .port_j_oe(j_oe),
    .port_j_pullup(j_pu), .port_j_in_en(j_ie), .pin_change_source(pcs), .irq(irq));
  ppcor_board #(.W(8)) i_board_a (.oe(a_oe), .out(a_out), .ext(ext_a), .pin(a_in));
  ppcor_board #(.W(8)) i_board_b (.oe(b_oe), .out(b_out), .ext(ext_b), .pin(b_in));
  ppcor_board #(.W(7)) i_board_j (.oe(j_oe), .out(j_out), .ext(ext_j), .pin(j_in));

  function automatic logic [7:0] pull(input logic [7:0] d, input logic [7:0] dir);
    pull = d & ~dir;
  endfunction : pull

  function automatic logic [7:0] in_en(input logic [6:0] m, input logic en);
    in_en = {1'b0, ~(m & {7{en}})};
  endfunction : in_en

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input string name, input logic [5:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    rd_chk("a_dir_rst", 6'h01, 8'h00);
    rd_chk("a_data_rst", 6'h02, 8'h00);
    rd_chk("b_dir_rst", 6'h04, 8'h00);
    rd_chk("b_data_rst", 6'h05, 8'h00);
    for (int i = 0; i < 24; i++) begin
      d0 = $random(seed);
      d1 = $random(seed);
      d2 = (i == 0) ? 8'hff : 8'($random(seed));
      d3 = (i == 1) ? 8'hff : 8'($random(seed));
      ext_a <= $random(seed);
      ext_b <= $random(seed);
      wr_reg(6'h01, d0);
      wr_reg(6'h02, d1);
      wr_reg(6'h04, d2);
      wr_reg(6'h05, d3);
      rd_chk("a_dir", 6'h01, d0);
      rd_chk("a_data", 6'h02, d1);
      rd_chk("b_dir", 6'h04, d2);
      rd_chk("b_data", 6'h05, d3);
      rd_chk("a_pins", 6'h00, (d0 & d1) | (~d0 & ext_a));
      chk("a_out", d1, a_out);
      chk("a_oe", d0, a_oe);
      chk("a_pu", pull(d1, d0), a_pu);
      chk("b_out", d3, b_out);
      chk("b_oe", d2, b_oe);
      chk("b_pu", pull(d3, d2), b_pu);
    end
    wr_reg(6'h01, 8'h00);
    ext_a <= 8'ha5;
    wr_reg(6'h00, 8'h3c);
    rd_chk("a_pins_ro", 6'h00, 8'ha5);
    wr_reg(6'h3f, 8'hff);
    rd_chk("unmapped", 6'h3f, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d0 = $random(seed);
      d1 = $random(seed);
      wr_reg(6'h11, d0);
      wr_reg(6'h12, d1);
      idle(1);
      chk("j_out", {1'b0, d1[6:0]}, {1'b0, j_out});
      chk("j_oe", {1'b0, d0[6:0]}, {1'b0, j_oe});
      chk("j_pu", pull({1'b0, d1[6:0]}, d0), {1'b0, j_pu});
      rd_chk("j_dir", 6'h11, {1'b0, d0[6:0]});
    end
    wr_reg(6'h11, 8'h00);
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      ext_j <= 7'(1 << i);
      idle(2);
      chk("pc_source", {1'b0, 7'(1 << i)}, {1'b0, pcs});
      rd_chk("j_pins", 6'h10, {1'b0, 7'(1 << i)});
    end
    for (int e = 0; e < 2; e++) begin
      d0 = $random(seed);
      wr_reg(6'h13, d0);
      wr_reg(6'h14, 8'(e));
      idle(1);
      chk("j_in_en", in_en(d0[6:0], e[0]), {1'b0, j_ie});
    end
    wr_reg(6'h13, 8'h7f);
    wr_reg(6'h16, 8'h7f);
    wr_reg(6'h15, 8'h7f);
    idle(2);
    chk("irq_idle", 8'h00, {7'h00, irq});
    @(posedge mclk);
    ext_j <= ext_j ^ 7'h08;
    idle(2);
    chk("irq_set", 8'h01, {7'h00, irq});
    rd_chk("int_stat", 6'h15, 8'h08);
    wr_reg(6'h15, 8'h08);
    idle(2);
    chk("irq_clr", 8'h00, {7'h00, irq});
    wr_reg(6'h16, 8'h00);
    @(posedge mclk);
    ext_j <= ext_j ^ 7'h20;
    idle(3);
    chk("irq_masked", 8'h00, {7'h00, irq});
    rd_chk("int_stat_m", 6'h15, 8'h20);
    wr_reg(6'h16, 8'h7f);
    idle(2);
    chk("irq_unmask", 8'h01, {7'h00, irq});
    rd_chk("int_mask", 6'h16, 8'h7f);
    rd_chk("pc_mask", 6'h13, 8'h7f);
    rd_chk("pc_ctrl", 6'h14, 8'h01);
    tally_and_finish();
  end
endmodule : ppcor_bench
